/* File: sar_adc_pkg.sv */
package sar_adc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RES_BITS = 8;
    localparam int IDX_W = 3;
    localparam int CNT_W = 7;
    localparam int HI_W = 8;
    // Conversion time, typical and allowed window, in ns
    localparam int CONV_TIME_NS = 25000;
    localparam int CONV_MIN_NS = 15000;
    localparam int CONV_MAX_NS = 40000;
    localparam int BIT_CYC = CONV_TIME_NS / (RES_BITS * CLK_PERIOD_NS);
    // Release delay after start goes high (about), rounded down
    localparam int RELEASE_NS = 1500;
    localparam int RELEASE_CYC = RELEASE_NS / CLK_PERIOD_NS;
    // Least high pulse that clears the converter, rounded up
    localparam int MIN_PULSE_NS = 2000;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest delay from flag low to data enabled, rounded down
    localparam int DATA_EN_NS = 500;
    localparam int DATA_EN_CYC = DATA_EN_NS / CLK_PERIOD_NS;
    localparam logic [RES_BITS-1:0] MSB_TRIAL = 8'h80;
    localparam logic [RES_BITS-1:0] CODE_ZERO = 8'h00;
    localparam logic [IDX_W-1:0] IDX_MSB = 3'h7;
    localparam logic [IDX_W-1:0] IDX_LSB = 3'h0;
    localparam logic [IDX_W-1:0] IDX_STEP = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_STEP = 7'h01;
    localparam logic [HI_W-1:0] HI_ZERO = 8'h00;
    localparam logic [HI_W-1:0] HI_STEP = 8'h01;
    localparam logic [HI_W-1:0] HI_SAT = 8'hFF;
endpackage

/* File: pin_sync3.sv */
`timescale 1ns/100ps
module pin_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic [2:0] ff;
        logic level;
    } sync_t;

    sync_t sync_q;
    sync_t sync_d;

    always_comb begin
        sync_d = sync_q;
        sync_d.ff = {sync_q.ff[1:0], pin};
        // Change accepted only once stages two and three agree
        if (sync_q.ff[1] == sync_q.ff[2]) begin
            sync_d.level = sync_q.ff[2];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_q <= '{ff: {3{RESET_VAL}}, level: RESET_VAL};
        end else begin
            sync_q <= sync_d;
        end
    end

    assign level = sync_q.level;
endmodule

/* File: sar_adc_ctrl.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Trial bits run from MSB down to LSB
// - Keep bit if sum below input, else clear
// - Register holds final binary code after LSB
// - Flag low and outputs enabled at end
// - Start high blanks outputs, re-arms register
// - Open range pin gives offset binary coding
// - Standby: outputs open, flag high, wait low
// - Data within 500 ns; release 1.5 us
// - High aborts conversion; 2 us pulse clears
module sar_adc_ctrl #(
    parameter int BIT_CYC = sar_adc_pkg::BIT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic blank_convert,
    input wire logic comp_below,
    input wire logic range_open,
    output logic [7:0] dac_code,
    output logic bipolar_offset_en,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic result_valid_n
);
    localparam int TOTAL_NS = BIT_CYC * sar_adc_pkg::RES_BITS * sar_adc_pkg::CLK_PERIOD_NS;
    localparam logic [sar_adc_pkg::CNT_W-1:0] BIT_LAST = sar_adc_pkg::CNT_W'(BIT_CYC - 1);
    localparam logic [sar_adc_pkg::HI_W-1:0] RELEASE_LAST = sar_adc_pkg::HI_W'(sar_adc_pkg::RELEASE_CYC - 1);
    localparam logic [sar_adc_pkg::HI_W-1:0] CLEAR_LAST = sar_adc_pkg::HI_W'(sar_adc_pkg::MIN_PULSE_CYC - 1);

    // Sequencing rate must land the conversion inside its window
    if (BIT_CYC < 2 || BIT_CYC > (1 << sar_adc_pkg::CNT_W)) begin : g_bad_cyc
        $error("BIT_CYC outside counter range");
    end
    if (TOTAL_NS < sar_adc_pkg::CONV_MIN_NS || TOTAL_NS > sar_adc_pkg::CONV_MAX_NS) begin : g_bad_time
        $error("Conversion time outside allowed window");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STOP, ST_DONE} state_t;

    typedef struct packed {
        state_t st;
        logic [sar_adc_pkg::RES_BITS-1:0] approx;
        logic [sar_adc_pkg::IDX_W-1:0] idx;
        logic [sar_adc_pkg::CNT_W-1:0] cnt;
        logic [sar_adc_pkg::HI_W-1:0] hi_cnt;
        logic [sar_adc_pkg::RES_BITS-1:0] dout;
        logic oe;
        logic valid_n;
        logic offs;
    } ctl_t;

    ctl_t ctl_q;
    ctl_t ctl_d;
    logic start_s;
    logic comp_s;
    logic range_s;

    // Start idles high so a reset never triggers a conversion
    pin_sync3 #(.RESET_VAL(1'b1)) u_sync_start (
        .clk(clk),
        .nrst(nrst),
        .pin(blank_convert),
        .level(start_s)
    );

    pin_sync3 #(.RESET_VAL(1'b0)) u_sync_comp (
        .clk(clk),
        .nrst(nrst),
        .pin(comp_below),
        .level(comp_s)
    );

    pin_sync3 #(.RESET_VAL(1'b0)) u_sync_range (
        .clk(clk),
        .nrst(nrst),
        .pin(range_open),
        .level(range_s)
    );

    always_comb begin
        logic [sar_adc_pkg::RES_BITS-1:0] decided;
        decided = ctl_q.approx;
        ctl_d = ctl_q;
        // Offset current switch follows the range pin
        ctl_d.offs = range_s;
        if (!start_s) begin
            ctl_d.hi_cnt = sar_adc_pkg::HI_ZERO;
        end else if (ctl_q.hi_cnt != sar_adc_pkg::HI_SAT) begin
            ctl_d.hi_cnt = ctl_q.hi_cnt + sar_adc_pkg::HI_STEP;
        end
        if (!comp_s) begin
            decided[ctl_q.idx] = 1'b0;
        end
        case (ctl_q.st)
            ST_IDLE: begin
                ctl_d.oe = 1'b0;
                ctl_d.valid_n = 1'b1;
                if (!start_s) begin
                    ctl_d.st = ST_CONV;
                    ctl_d.approx = sar_adc_pkg::MSB_TRIAL;
                    ctl_d.idx = sar_adc_pkg::IDX_MSB;
                    ctl_d.cnt = sar_adc_pkg::CNT_ZERO;
                end
            end
            ST_CONV: begin
                if (start_s) begin
                    // Abort; flag and outputs stay as they are
                    ctl_d.st = ST_STOP;
                end else if (ctl_q.cnt == BIT_LAST) begin
                    ctl_d.cnt = sar_adc_pkg::CNT_ZERO;
                    ctl_d.approx = decided;
                    if (ctl_q.idx == sar_adc_pkg::IDX_LSB) begin
                        ctl_d.st = ST_DONE;
                        ctl_d.dout = decided;
                        ctl_d.valid_n = 1'b0;
                        ctl_d.oe = 1'b1;
                    end else begin
                        ctl_d.approx[ctl_q.idx - sar_adc_pkg::IDX_STEP] = 1'b1;
                        ctl_d.idx = ctl_q.idx - sar_adc_pkg::IDX_STEP;
                    end
                end else begin
                    ctl_d.cnt = ctl_q.cnt + sar_adc_pkg::CNT_STEP;
                end
            end
            ST_STOP: begin
                if (!start_s) begin
                    ctl_d.st = ST_CONV;
                    ctl_d.approx = sar_adc_pkg::MSB_TRIAL;
                    ctl_d.idx = sar_adc_pkg::IDX_MSB;
                    ctl_d.cnt = sar_adc_pkg::CNT_ZERO;
                end else if (ctl_q.hi_cnt == CLEAR_LAST) begin
                    ctl_d.approx = sar_adc_pkg::CODE_ZERO;
                end
            end
            ST_DONE: begin
                // Short high glitches leave the result in place
                if (start_s && ctl_q.hi_cnt == RELEASE_LAST) begin
                    ctl_d.st = ST_IDLE;
                    ctl_d.oe = 1'b0;
                    ctl_d.valid_n = 1'b1;
                    ctl_d.approx = sar_adc_pkg::CODE_ZERO;
                end
            end
            default: begin
                ctl_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= '{st: ST_IDLE, approx: sar_adc_pkg::CODE_ZERO, idx: sar_adc_pkg::IDX_MSB,
                       cnt: sar_adc_pkg::CNT_ZERO, hi_cnt: sar_adc_pkg::HI_ZERO,
                       dout: sar_adc_pkg::CODE_ZERO, oe: 1'b0, valid_n: 1'b1, offs: 1'b0};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign dac_code = ctl_q.approx;
    assign bipolar_offset_en = ctl_q.offs;
    assign data_out = ctl_q.dout;
    assign data_oe = ctl_q.oe;
    assign result_valid_n = ctl_q.valid_n;

    chk_msb_first: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_IDLE && !start_s) |=> (dac_code == sar_adc_pkg::MSB_TRIAL && ctl_q.st == ST_CONV))
        else $error("Conversion did not begin with MSB trial");

    chk_bit_decide: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_CONV && !start_s && ctl_q.cnt == BIT_LAST)
        |=> (dac_code[$past(ctl_q.idx)] == $past(comp_s)))
        else $error("Trial bit not decided by comparator");

    chk_result_hold: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_DONE) |-> (data_out == dac_code))
        else $error("Result differs from approximation register");

    chk_valid_data: assert property (@(posedge clk) disable iff (!nrst)
        $fell(result_valid_n) |-> (data_oe && $past(ctl_q.idx) == sar_adc_pkg::IDX_LSB))
        else $error("Flag fell without data enabled after LSB");

    chk_blank_rearm: assert property (@(posedge clk) disable iff (!nrst)
        $fell(data_oe) |-> (result_valid_n && ctl_q.st == ST_IDLE && dac_code == sar_adc_pkg::CODE_ZERO))
        else $error("Blanking did not re-arm register");

    chk_range_sel: assert property (@(posedge clk) disable iff (!nrst)
        ##1 (bipolar_offset_en == $past(range_s)))
        else $error("Offset switch not following range pin");

    chk_standby_quiet: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_IDLE && start_s) |=> (ctl_q.st == ST_IDLE && result_valid_n && !data_oe))
        else $error("Standby left while start held high");

    chk_release_time: assert property (@(posedge clk) disable iff (!nrst)
        $rose(result_valid_n) |-> ($past(ctl_q.hi_cnt) == RELEASE_LAST && !data_oe))
        else $error("Flag released at wrong delay");

    chk_abort_hold: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_CONV && start_s) |=> (ctl_q.st == ST_STOP && $stable(result_valid_n) && $stable(data_oe)))
        else $error("Abort changed flag or outputs");

    chk_bit_step: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_CONV && !start_s && ctl_q.cnt == BIT_LAST && ctl_q.idx != sar_adc_pkg::IDX_LSB)
        |=> (ctl_q.idx == $past(ctl_q.idx) - sar_adc_pkg::IDX_STEP && dac_code[ctl_q.idx]))
        else $error("Next lower trial bit not set");

    // Code must sit still for the whole bit period or the comparator misjudges
    chk_bit_period: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_CONV && !start_s && ctl_q.cnt != BIT_LAST)
        |=> (ctl_q.cnt == $past(ctl_q.cnt) + sar_adc_pkg::CNT_STEP && $stable(dac_code)))
        else $error("Trial code moved inside its bit period");

    chk_done_hold: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_DONE && !start_s) |=> (ctl_q.st == ST_DONE && !result_valid_n && data_oe))
        else $error("Result dropped while start held low");

    chk_clear_pulse: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_STOP && start_s && ctl_q.hi_cnt == CLEAR_LAST)
        |=> (dac_code == sar_adc_pkg::CODE_ZERO))
        else $error("Long high pulse did not clear register");

    chk_restart_msb: assert property (@(posedge clk) disable iff (!nrst)
        (ctl_q.st == ST_STOP && !start_s) |=> (dac_code == sar_adc_pkg::MSB_TRIAL && ctl_q.st == ST_CONV))
        else $error("Restart after abort not from MSB");
endmodule

/* File: comp_model.sv */
`timescale 1ns/100ps
module comp_model (
    input wire logic [7:0] dac_code,
    input wire logic [7:0] level,
    output logic comp_below
);
    // Input sits half a step above level, so a trial equal to it stays set
    assign comp_below = (dac_code <= level);
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic blank_convert = 1'b1;
    logic range_open = 1'b0;
    logic comp_below;
    logic [7:0] level = 8'h00;
    logic [7:0] dac_code;
    logic [7:0] data_out;
    logic bipolar_offset_en;
    logic data_oe;
    logic result_valid_n;
    logic [31:0] lfsr = 32'h21DB80E7;
    int n_errors = 0;
    int tests_run = 0;

    initial forever #12.5 clk = ~clk;

    sar_adc_ctrl u_sar_adc_ctrl (.clk(clk), .nrst(nrst), .blank_convert(blank_convert), .comp_below(comp_below),
        .range_open(range_open), .dac_code(dac_code), .bipolar_offset_en(bipolar_offset_en), .data_out(data_out),
        .data_oe(data_oe), .result_valid_n(result_valid_n));
    comp_model u_comp_model (.dac_code(dac_code), .level(level), .comp_below(comp_below));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] sar_expect(input logic [7:0] lv);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            c[i] = 1'b1;
            if (c > lv) c[i] = 1'b0;
        end
        return c;
    endfunction

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for the flag level; a hang ends the run
    task automatic wait_flag(input logic lvl, input int bound, output int n);
        n = 0;
        while (result_valid_n !== lvl && n < bound) begin
            @(negedge clk);
            n++;
        end
        if (result_valid_n !== lvl) begin
            check("flag wait", lvl, result_valid_n);
            stop_test();
        end
    endtask

    task automatic convert(input logic [7:0] lv, input logic rng);
        int n;
        int t;
        logic [7:0] exp;
        logic [7:0] m;
        exp = sar_expect(lv);
        level = lv;
        range_open = rng;
        blank_convert = 1'b0;
        n = 0;
        while (dac_code === 8'h00 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check("first trial", 8'h80, dac_code);
        t = 0;
        for (int k = 0; k < 8; k++) begin
            repeat (k == 0 ? 60 : 125) @(negedge clk);
            t += (k == 0 ? 60 : 125);
            m = 8'hFF << (8 - k);
            check("trial code", (exp & m) | (8'h80 >> k), dac_code);
            check("flag busy", 1'b1, result_valid_n);
        end
        wait_flag(1'b0, 200, n);
        check("conv cycles ok", 1'b1, (t + n >= 998) && (t + n <= 1002));
        check("result", exp, data_out);
        check("register", exp, dac_code);
        check("oe done", 1'b1, data_oe);
        check("offset sw", rng, bipolar_offset_en);
        // Short high in the done state must be ignored
        blank_convert = 1'b1;
        repeat (20) @(negedge clk);
        blank_convert = 1'b0;
        repeat (20) @(negedge clk);
        check("short high flag", 1'b0, result_valid_n);
        check("short high data", exp, data_out);
        blank_convert = 1'b1;
        repeat (30) @(negedge clk);
        check("hold flag", 1'b0, result_valid_n);
        wait_flag(1'b1, 100, n);
        check("release ok", 1'b1, (30 + n >= 58) && (30 + n <= 66));
        check("oe blank", 1'b0, data_oe);
        repeat (40) @(negedge clk);
        check("rearmed", 8'h00, dac_code);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        check("timeout", 1'b0, 1'b1);
        stop_test();
    end

    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (50) @(negedge clk);
        check("standby flag", 1'b1, result_valid_n);
        check("standby oe", 1'b0, data_oe);
        convert(8'h00, 1'b1);
        convert(8'hFF, 1'b0);
        convert(8'h80, 1'b1);
        // Abort mid-conversion, then a fresh one from the top
        blank_convert = 1'b0;
        repeat (300) @(negedge clk);
        blank_convert = 1'b1;
        repeat (20) @(negedge clk);
        check("abort flag", 1'b1, result_valid_n);
        check("abort oe", 1'b0, data_oe);
        repeat (100) @(negedge clk);
        check("abort clear", 8'h00, dac_code);
        for (int r = 0; r < 5; r++) begin
            lfsr = next_rand(lfsr);
            convert(lfsr[7:0], lfsr[8]);
        end
        // Reset in mid-conversion returns every output to idle
        blank_convert = 1'b0;
        repeat (200) @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check("reset flag", 1'b1, result_valid_n);
        check("reset oe", 1'b0, data_oe);
        check("reset code", 8'h00, dac_code);
        check("reset offset sw", 1'b0, bipolar_offset_en);
        blank_convert = 1'b1;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (20) @(negedge clk);
        check("idle after reset", 8'h00, dac_code);
        convert(8'h01, 1'b0);
        stop_test();
    end
endmodule
